// [logic/pirs_bank.sv]
`timescale 1ns/10ps
`default_nettype none
module pirs_bank import pirs_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic brownout_reset_i,
    input wire logic other_reset_i,
    input wire pirs_req_t req_i,
    input wire pirs_periph_ev_t periph_ev_i,
    input wire pirs_serial_ev_t serial_ev_i,
    input wire pirs_ccp_mode_t ccp_mode_i,
    input wire pirs_osc_mode_t osc_mode_i,
    input wire logic [7:0] peripheral_enables_one_i,
    input wire logic peripheral_irq_gate_i,
    output logic [7:0] rdata_o,
    output logic periph_irq_o,
    output pirs_clk_src_t clk_src_o,
    output logic osc_speed_select_o
);

    generate
        if (ADDR_W != 8) begin : g_bad_addr
            $error("pirs_bank supports an 8-bit register address only");
        end
    endgenerate

    function automatic pirs_sel_t decode(input logic [7:0] a);
        pirs_sel_t s;
        s = PIRS_SEL_NONE;
        if (a == PIRS_OFS_FLAGS_ONE) begin
            s = PIRS_SEL_FLAGS_ONE;
        end else if (a == PIRS_OFS_FLAGS_TWO) begin
            s = PIRS_SEL_FLAGS_TWO;
        end else if (a == PIRS_OFS_ENABLES_TWO) begin
            s = PIRS_SEL_ENABLES_TWO;
        end else if (a == PIRS_OFS_POWER_CTRL) begin
            s = PIRS_SEL_POWER;
        end
        return s;
    endfunction

    logic [7:0] flags_one;
    logic [7:0] flags_two;
    logic [7:0] enables_two;
    logic osc_speed_select;
    logic power_on_status;
    logic brownout_reset_status;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic serial_set;
    logic ccp_set;
    logic sync_reset;
    pirs_sel_t wsel;
    pirs_sel_t rsel;
    logic [7:0] next_flags_one;
    logic [7:0] next_flags_two;
    logic [7:0] power_view;
    logic [7:0] next_rdata;
    pirs_clk_src_t next_clk_src;

    assign sync_reset = brownout_reset_i | other_reset_i;
    assign wsel = req_i.wr ? decode(req_i.addr) : PIRS_SEL_NONE;
    assign rsel = req_i.rd ? decode(req_i.addr) : PIRS_SEL_NONE;

    // Any completion or master sequence end; master-only events come from the port
    assign serial_set = serial_ev_i.xfer_done | serial_ev_i.start_done
        | serial_ev_i.stop_done | serial_ev_i.restart_done
        | serial_ev_i.ack_done | serial_ev_i.idle_start_seen;

    always_comb begin
        ccp_set = 1'b0;
        unique case (ccp_mode_i)
            PIRS_CCP_CAPTURE: ccp_set = periph_ev_i.ccp_capture;
            PIRS_CCP_COMPARE: ccp_set = periph_ev_i.ccp_match;
            PIRS_CCP_OFF, PIRS_CCP_PWM: ccp_set = 1'b0;
        endcase
    end

    // Sets ignore every enable and the interrupt gate; CCP mode and master_tx still qualify their events
    always_comb begin
        set_one = PIRS_RST_FLAGS;
        set_one[PIRS_BIT_CONV] = periph_ev_i.conv_done;
        set_one[PIRS_BIT_SERIAL] = serial_set;
        set_one[PIRS_BIT_CCP] = ccp_set;
        set_one[PIRS_BIT_TIMER2_COUNT] = periph_ev_i.timer2_match;
        set_one[PIRS_BIT_TIMER1_COUNT] = periph_ev_i.timer1_overflow;
        set_two = PIRS_RST_FLAGS;
        set_two[PIRS_BIT_LOWV] = periph_ev_i.low_voltage;
        set_two[PIRS_BIT_BUSCOL] = serial_ev_i.bus_collision
            & serial_ev_i.master_tx;
    end

    // Set ORed after the write so an event in the write cycle survives
    always_comb begin
        next_flags_one = flags_one;
        next_flags_two = flags_two;
        if (wsel == PIRS_SEL_FLAGS_ONE) begin
            next_flags_one = req_i.wdata;
        end
        if (wsel == PIRS_SEL_FLAGS_TWO) begin
            next_flags_two = req_i.wdata;
        end
        next_flags_one = (next_flags_one | set_one) & PIRS_MASK_FLAGS_ONE;
        next_flags_two = (next_flags_two | set_two) & PIRS_MASK_TWO;
    end

    // No hardware clear path exists, only writes and resets
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            flags_one <= PIRS_RST_FLAGS;
            flags_two <= PIRS_RST_FLAGS;
        end else if (sync_reset) begin
            flags_one <= PIRS_RST_FLAGS;
            flags_two <= PIRS_RST_FLAGS;
        end else begin
            flags_one <= next_flags_one;
            flags_two <= next_flags_two;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            enables_two <= PIRS_RST_ENABLES;
        end else if (sync_reset) begin
            enables_two <= PIRS_RST_ENABLES;
        end else if (wsel == PIRS_SEL_ENABLES_TWO) begin
            enables_two <= req_i.wdata & PIRS_MASK_TWO;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            osc_speed_select <= PIRS_RST_OSC;
        end else if (sync_reset) begin
            osc_speed_select <= PIRS_RST_OSC;
        end else if (wsel == PIRS_SEL_POWER) begin
            osc_speed_select <= req_i.wdata[PIRS_BIT_OSC];
        end
    end

    // Brownout and other resets keep the reset-cause bits they did not cause; power-on reset clears both
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            power_on_status <= PIRS_RST_POR;
            brownout_reset_status <= PIRS_RST_BOR_AT_POR;
        end else if (brownout_reset_i) begin
            brownout_reset_status <= PIRS_RST_POR;
        end else if (other_reset_i) begin
            power_on_status <= power_on_status;
        end else if (wsel == PIRS_SEL_POWER) begin
            power_on_status <= req_i.wdata[PIRS_BIT_POR];
            brownout_reset_status <= req_i.wdata[PIRS_BIT_BOR];
        end
    end

    always_comb begin
        power_view = PIRS_READ_ZERO;
        power_view[PIRS_BIT_OSC] = osc_speed_select;
        power_view[PIRS_BIT_POR] = power_on_status;
        power_view[PIRS_BIT_BOR] = brownout_reset_status;
    end

    always_comb begin
        next_rdata = PIRS_READ_ZERO;
        unique case (rsel)
            PIRS_SEL_FLAGS_ONE: next_rdata = flags_one;
            PIRS_SEL_FLAGS_TWO: next_rdata = flags_two;
            PIRS_SEL_ENABLES_TWO: next_rdata = enables_two;
            PIRS_SEL_POWER: next_rdata = power_view;
            default: next_rdata = PIRS_READ_ZERO;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= PIRS_READ_ZERO;
        end else begin
            rdata_o <= next_rdata;
        end
    end

    // Global enable is left to the core
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            periph_irq_o <= 1'b0;
        end else begin
            periph_irq_o <= peripheral_irq_gate_i
                & (|(flags_one & peripheral_enables_one_i)
                | |(flags_two & enables_two));
        end
    end

    // Speed bit matters only for the two on-chip-rate modes
    always_comb begin
        next_clk_src = PIRS_SRC_PRIMARY;
        unique case (osc_mode_i)
            PIRS_OSC_INT_RC: next_clk_src = osc_speed_select ? PIRS_SRC_INT_FAST
                : PIRS_SRC_SLOW;
            PIRS_OSC_EXT_RES: next_clk_src = osc_speed_select ? PIRS_SRC_RES_SET
                : PIRS_SRC_SLOW;
            PIRS_OSC_LP, PIRS_OSC_XT, PIRS_OSC_HS, PIRS_OSC_EC:
                next_clk_src = PIRS_SRC_PRIMARY;
            default: next_clk_src = PIRS_SRC_PRIMARY;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            clk_src_o <= PIRS_SRC_PRIMARY;
            osc_speed_select_o <= PIRS_RST_OSC;
        end else begin
            clk_src_o <= next_clk_src;
            osc_speed_select_o <= osc_speed_select;
        end
    end

endmodule
`default_nettype wire

// [logic/pirs_pkg.sv]
`default_nettype none
package pirs_pkg;

    localparam int unsigned PIRS_DATA_W = 8;

    localparam logic [7:0] PIRS_OFS_FLAGS_ONE = 8'h0C;
    localparam logic [7:0] PIRS_OFS_FLAGS_TWO = 8'h0D;
    localparam logic [7:0] PIRS_OFS_ENABLES_TWO = 8'h8D;
    localparam logic [7:0] PIRS_OFS_POWER_CTRL = 8'h8E;

    localparam int unsigned PIRS_BIT_CONV = 6;
    localparam int unsigned PIRS_BIT_SERIAL = 3;
    localparam int unsigned PIRS_BIT_CCP = 2;
    localparam int unsigned PIRS_BIT_TIMER2_COUNT = 1;
    localparam int unsigned PIRS_BIT_TIMER1_COUNT = 0;
    localparam int unsigned PIRS_BIT_LOWV = 7;
    localparam int unsigned PIRS_BIT_BUSCOL = 3;
    localparam int unsigned PIRS_BIT_OSC = 3;
    localparam int unsigned PIRS_BIT_POR = 1;
    localparam int unsigned PIRS_BIT_BOR = 0;

    localparam logic [7:0] PIRS_MASK_FLAGS_ONE = 8'h4F;
    localparam logic [7:0] PIRS_MASK_TWO = 8'h88;
    localparam logic [7:0] PIRS_MASK_POWER = 8'h0B;

    localparam logic [7:0] PIRS_RST_FLAGS = 8'h00;
    localparam logic [7:0] PIRS_RST_ENABLES = 8'h00;
    localparam logic PIRS_RST_OSC = 1'b1;
    localparam logic PIRS_RST_POR = 1'b0;
    localparam logic PIRS_RST_BOR_AT_POR = 1'b0;
    localparam logic [7:0] PIRS_READ_ZERO = 8'h00;

    localparam int unsigned PIRS_INTERNAL_RC_OSC_MODE_FAST_HZ = 4_000_000;
    localparam int unsigned PIRS_SLOW_HZ = 37_000;

    typedef enum logic [2:0] {
        PIRS_OSC_LP = 3'h0,
        PIRS_OSC_XT = 3'h1,
        PIRS_OSC_HS = 3'h2,
        PIRS_OSC_EC = 3'h3,
        PIRS_OSC_INT_RC = 3'h4,
        PIRS_OSC_EXT_RES = 3'h5
    } pirs_osc_mode_t;

    typedef enum logic [1:0] {
        PIRS_SRC_PRIMARY = 2'h0,
        PIRS_SRC_INT_FAST = 2'h1,
        PIRS_SRC_RES_SET = 2'h2,
        PIRS_SRC_SLOW = 2'h3
    } pirs_clk_src_t;

    typedef enum logic [1:0] {
        PIRS_CCP_OFF = 2'h0,
        PIRS_CCP_CAPTURE = 2'h1,
        PIRS_CCP_COMPARE = 2'h2,
        PIRS_CCP_PWM = 2'h3
    } pirs_ccp_mode_t;

    typedef enum logic [2:0] {
        PIRS_SEL_NONE = 3'h0,
        PIRS_SEL_FLAGS_ONE = 3'h1,
        PIRS_SEL_FLAGS_TWO = 3'h2,
        PIRS_SEL_ENABLES_TWO = 3'h3,
        PIRS_SEL_POWER = 3'h4
    } pirs_sel_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pirs_req_t;

    typedef struct packed {
        logic xfer_done;
        logic start_done;
        logic stop_done;
        logic restart_done;
        logic ack_done;
        logic idle_start_seen;
        logic bus_collision;
        logic master_tx;
    } pirs_serial_ev_t;

    typedef struct packed {
        logic conv_done;
        logic ccp_capture;
        logic ccp_match;
        logic timer2_match;
        logic timer1_overflow;
        logic low_voltage;
    } pirs_periph_ev_t;

endpackage
`default_nettype wire

// [tb/pirs_bank_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module pirs_bank_monitor import pirs_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic brownout_reset_i,
    input wire logic other_reset_i,
    input wire pirs_req_t req_i,
    input wire pirs_osc_mode_t osc_mode_i,
    input wire logic peripheral_irq_gate_i,
    input wire logic [7:0] rdata_o,
    input wire logic periph_irq_o,
    input wire pirs_clk_src_t clk_src_o,
    input wire logic osc_speed_select_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // A write right after the reset could rightly change the speed bit
    sequence sync_rst_s;
        (brownout_reset_i || other_reset_i) ##1 !req_i.wr;
    endsequence
    rd_idle_a: assert property (!$past(req_i.rd) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    f1_mask_a: assert property ($past(req_i.rd) && $past(req_i.addr) == 8'h0C
        |-> (rdata_o & 8'hB0) == 8'h00) else $error("flags one spare bit set");
    f2_mask_a: assert property ($past(req_i.rd) && $past(req_i.addr) == 8'h0D
        |-> (rdata_o & 8'h77) == 8'h00) else $error("flags two spare bit set");
    pwr_mask_a: assert property ($past(req_i.rd) && $past(req_i.addr) == 8'h8E
        |-> (rdata_o & 8'hF4) == 8'h00) else $error("power spare bit set");
    osc_other_a: assert property (!($past(osc_mode_i) inside {PIRS_OSC_INT_RC,
        PIRS_OSC_EXT_RES}) |-> clk_src_o == PIRS_SRC_PRIMARY) else $error("speed not ignored");
    osc_internal_rc_osc_mode_a: assert property ($past(osc_mode_i) == PIRS_OSC_INT_RC |->
        clk_src_o == (osc_speed_select_o ? PIRS_SRC_INT_FAST : PIRS_SRC_SLOW))
        else $error("internal oscillator rate wrong");
    gate_off_a: assert property (!$past(peripheral_irq_gate_i) |-> !periph_irq_o)
        else $error("interrupt passed a closed gate");
    sync_speed_a: assert property (sync_rst_s |=> osc_speed_select_o)
        else $error("speed bit not one after reset");
endmodule
bind pirs_bank pirs_bank_monitor u_pirs_bank_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .brownout_reset_i(brownout_reset_i), .other_reset_i(other_reset_i), .req_i(req_i),
    .osc_mode_i(osc_mode_i), .peripheral_irq_gate_i(peripheral_irq_gate_i),
    .rdata_o(rdata_o), .periph_irq_o(periph_irq_o), .clk_src_o(clk_src_o),
    .osc_speed_select_o(osc_speed_select_o));
`default_nettype wire

// [tb/pirs_periph_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pirs_periph_model import pirs_pkg::*; (
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [3:0] sel_i,
    input wire logic master_tx_i,
    output pirs_periph_ev_t periph_ev_o,
    output pirs_serial_ev_t serial_ev_o
);
    logic [13:0] pulse;
    // One-cycle pulses: a held level would keep setting the flag
    always_ff @(posedge clk_i) begin
        pulse <= go_i ? 14'h0001 << sel_i : 14'h0000;
    end
    assign {periph_ev_o, serial_ev_o} = pulse | {13'h0000, master_tx_i};
endmodule
`default_nettype wire

// [tb/pirs_bank_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pirs_bank_tb import pirs_pkg::*; ;
    `define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
        $display("unexpected at %0t: got %h exp %h", $time, a, b); end end
    logic clk, irq, spd;
    logic rst_b = 1'b0, bo_rst = 1'b0, ot_rst = 1'b0, gate = 1'b0, go = 1'b0, mtx = 1'b0;
    logic [3:0] sel = 4'h0;
    logic [7:0] en1 = 8'h00, rdata;
    logic [31:0] rs = 32'h0000_6635;
    pirs_req_t req = '0;
    pirs_ccp_mode_t ccp = PIRS_CCP_OFF;
    pirs_osc_mode_t osc = PIRS_OSC_LP;
    pirs_clk_src_t src;
    pirs_periph_ev_t pev;
    pirs_serial_ev_t sev;
    int err_count = 0, checked = 0, cyc = 0;
    int mdl [logic [7:0]] = '{8'h0C: 0, 8'h0D: 0, 8'h8D: 0, 8'h8E: 8};
    int msk [logic [7:0]] = '{8'h0C: 'h4F, 8'h0D: 'h88, 8'h8D: 'h88, 8'h8E: 'h0B};
    logic [7:0] ofs [4] = '{8'h0C, 8'h0D, 8'h8D, 8'h8E};
    pirs_periph_model u_pirs_periph_model (.clk_i(clk), .go_i(go), .sel_i(sel),
        .master_tx_i(mtx), .periph_ev_o(pev), .serial_ev_o(sev));
    pirs_bank u_pirs_bank (.clk_i(clk), .rst_b_i(rst_b), .brownout_reset_i(bo_rst),
        .other_reset_i(ot_rst), .req_i(req), .periph_ev_i(pev), .serial_ev_i(sev),
        .ccp_mode_i(ccp), .osc_mode_i(osc), .peripheral_enables_one_i(en1),
        .peripheral_irq_gate_i(gate), .rdata_o(rdata), .periph_irq_o(irq),
        .clk_src_o(src), .osc_speed_select_o(spd));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic pirs_clk_src_t exp_src(int m, logic s);
        if (m == 4) return s ? PIRS_SRC_INT_FAST : PIRS_SRC_SLOW;
        if (m == 5) return s ? PIRS_SRC_RES_SET : PIRS_SRC_SLOW;
        return PIRS_SRC_PRIMARY;
    endfunction
    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
        if (msk.exists(a)) mdl[a] = d & msk[a];
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1;
        `CHK(rdata, 8'(mdl.exists(a) ? mdl[a] : 0))
    endtask
    task automatic fire(input int s, input logic clr);
        @(posedge clk);
        go <= 1'b1;
        sel <= s[3:0];
        @(posedge clk);
        go <= 1'b0;
        req.wr <= clr;
        req.addr <= 8'h0C;
        req.wdata <= 8'h00;
        @(posedge clk);
        req.wr <= 1'b0;
        if (clr) mdl[8'h0C] = 0;
        case (s)
            1: if (mtx) mdl[8'h0D] |= 'h08;
            8: mdl[8'h0D] |= 'h80;
            9: mdl[8'h0C] |= 'h01;
            10: mdl[8'h0C] |= 'h02;
            11: if (ccp == PIRS_CCP_COMPARE) mdl[8'h0C] |= 'h04;
            12: if (ccp == PIRS_CCP_CAPTURE) mdl[8'h0C] |= 'h04;
            13: mdl[8'h0C] |= 'h40;
            default: mdl[8'h0C] |= 'h08;
        endcase
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            print_verdict();
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ofs[i]) rd(ofs[i]);
        foreach (ofs[i]) begin
            wr(ofs[i], 8'hFF);
            rd(ofs[i]);
        end
        wr(8'h8C, 8'hFF);
        rd(8'h8C);
        $display("test register map done");
        for (int k = 0; k < 52; k++) begin
            @(posedge clk);
            rs = xs(rs);
            ccp <= pirs_ccp_mode_t'(k / 13);
            mtx <= k[0];
            gate <= rs[1];
            en1 <= rs[15:8];
            wr(8'h0C, 8'h00);
            wr(8'h0D, 8'h00);
            wr(8'h8D, rs[23:16]);
            fire(k % 13 + 1, 1'b0);
            rd(8'h0C);
            rd(8'h0D);
            `CHK(irq, gate & ((mdl[8'h0C] & en1 | mdl[8'h0D] & mdl[8'h8D]) != 0))
        end
        fire(9, 1'b1);
        rd(8'h0C);
        $display("test events done");
        for (int k = 0; k < 12; k++) begin
            if (k % 6 == 0) wr(8'h8E, k == 0 ? 8'h0B : 8'h03);
            @(posedge clk);
            osc <= pirs_osc_mode_t'(k % 6);
            repeat (2) @(posedge clk);
            #1;
            `CHK(src, exp_src(k % 6, mdl[8'h8E] > 7))
            `CHK(spd, mdl[8'h8E] > 7)
        end
        $display("test oscillator done");
        for (int j = 0; j < 2; j++) begin
            @(posedge clk);
            ot_rst <= (j == 0);
            bo_rst <= (j == 1);
            @(posedge clk);
            ot_rst <= 1'b0;
            bo_rst <= 1'b0;
            foreach (ofs[i]) mdl[ofs[i]] = 0;
            mdl[8'h8E] = j == 0 ? 'h0B : 'h0A;
            foreach (ofs[i]) rd(ofs[i]);
        end
        // Power-on reset in mid-run: the power-on status bit was set, so clearing shows
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ofs[i]) mdl[ofs[i]] = 0;
        mdl[8'h8E] = 'h08;
        foreach (ofs[i]) rd(ofs[i]);
        `CHK(src, exp_src(osc, 1'b1))
        `CHK(irq, 1'b0)
        $display("test resets done");
        print_verdict();
    end
endmodule
`default_nettype wire
